// file: rbh_pkg.sv
// shared constants and carriers for the remote bit handshake block
package rbh_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the apb side
  localparam logic [7:0]  RBH_OFS_CTRL    = 8'h00; // terminal link mask
  localparam logic [7:0]  RBH_OFS_STATUS  = 8'h04; // returned bit image
  localparam logic [7:0]  RBH_OFS_REQUEST = 8'h08; // last received image
  localparam logic [7:0]  RBH_OFS_CMDCNT  = 8'h0c; // commands started

  // reset values
  localparam logic [8:0]  RBH_MASK_RST    = 9'h1ff; // all terminals live
  localparam logic [31:0] RBH_IMG_RST     = 32'h0000_0000;
  localparam logic [15:0] RBH_CNT_RST     = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // request image bit positions (master to device)
  localparam int RBH_RY_TERM_LO   = 2;  // terminal commands 2..8
  localparam int RBH_RY_TERM_HI   = 8;
  localparam int RBH_RY_TERM8     = 10; // terminal commands 10..11
  localparam int RBH_RY_TERM9     = 11;
  localparam int RBH_RY_MON       = 12; // monitor_request
  localparam int RBH_RY_REF       = 13; // reference_set_request
  localparam int RBH_RY_CMD       = 15; // command_exec_request
  localparam int RBH_RY_ALRST     = 26; // alarm_reset_request

  // status image bit positions (device to master)
  localparam int RBH_RX_FWD       = 0;  // running_forward_status
  localparam int RBH_RX_REV       = 1;  // running_reverse_status
  localparam int RBH_RX_TERM_LO   = 2;  // six output terminals 2..7
  localparam int RBH_RX_MON       = 12; // monitoring_status
  localparam int RBH_RX_REF       = 13; // reference set completed
  localparam int RBH_RX_CMD       = 15; // command_exec_done
  localparam int RBH_RX_ALARM     = 26; // alarm_state_status
  localparam int RBH_RX_READY     = 27; // station_ready_status

  ////////////////////////////////////////////////////////////////////////
  // drive side status, all asynchronous to SYS_CLK
  typedef struct packed {
    logic       fwd;      // motor turning forward
    logic       rev;      // motor turning reverse
    logic [5:0] term;     // output terminal states
    logic       trip;     // drive in trip
    logic       ready;    // drive ready after power-up or reset
    logic       mon_done; // monitor values stored
    logic       ref_done; // reference written into drive
    logic       cmd_done; // all command codes processed
  } rbh_drv_stat_s;

  // apb request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rbh_apb_req_s;

  // command handshake states, one-hot
  typedef enum logic [2:0] {
    RBH_CMD_IDLE = 3'b001,
    RBH_CMD_BUSY = 3'b010,
    RBH_CMD_DONE = 3'b100
  } rbh_cmd_e;

endpackage

// file: rbh_core.sv
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module rbh_core
  import rbh_pkg::*;
(
  // clock and reset
  input  wire logic          SYS_CLK,
  input  wire logic          RESETN,
  // apb slave
  input  wire rbh_apb_req_s  APB_REQ,
  output logic [31:0]        PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  // cyclic link image, same clock
  input  wire logic [31:0]   RY_IMAGE,
  input  wire logic          RY_STROBE,
  output logic [31:0]        RX_IMAGE,
  // drive side status pins
  input  wire rbh_drv_stat_s DRV_STAT,
  // drive side controls
  output logic               DRV_MON_REFRESH,
  output logic               DRV_REF_APPLY,
  output logic               DRV_CMD_START,
  output logic               DRV_ALARM_RESET,
  output logic [8:0]         DRV_TERM_CMD
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  rbh_drv_stat_s drv_s1_r;        // first sync stage, read by s2 only
  rbh_drv_stat_s drv_s2_r;        // synchronised drive status
  logic          trip_d_r;        // delayed trip for edge detect
  logic [31:0]   ry_cur_r;        // image currently in force
  logic [8:0]    mask_r;          // terminals operable over the link
  logic [15:0]   cmd_cnt_r;       // commands started since reset
  logic          mon_refresh_r;   // drive monitor refresh enable
  logic          ref_apply_r;     // drive reference apply enable
  logic          cmd_start_r;     // one-cycle command start
  logic          alarm_reset_r;   // one-cycle alarm reset
  logic [8:0]    term_cmd_r;      // gated terminal commands
  logic          monitoring_r;    // monitoring status
  logic          ref_done_r;      // reference set completed
  logic          alarm_r;         // alarm state status
  logic          alarm_nxt;
  logic          ready_r;         // station ready status
  logic          fwd_r;           // forward running status
  logic          rev_r;           // reverse running status
  logic [5:0]    term_st_r;       // output terminal states
  rbh_cmd_e      cmd_state_r;     // command handshake state
  rbh_cmd_e      cmd_state_nxt;
  logic          rise_cmd;        // command request rose this image
  logic          fall_alrst;      // alarm reset request fell
  logic          trip_rise;       // drive just tripped
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // true when an address is one of the mapped words
  function automatic logic rbh_mapped(input logic [7:0] a);
    rbh_mapped = (a == RBH_OFS_CTRL) || (a == RBH_OFS_STATUS) ||
                 (a == RBH_OFS_REQUEST) || (a == RBH_OFS_CMDCNT);
  endfunction

  // pick the nine terminal command bits out of an image
  function automatic logic [8:0] rbh_term_bits(input logic [31:0] img);
    rbh_term_bits = {img[RBH_RY_TERM9], img[RBH_RY_TERM8],
                     img[RBH_RY_TERM_HI:RBH_RY_TERM_LO]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // drive status synchroniser, two stages before any logic
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      drv_s1_r <= '0;
      drv_s2_r <= '0;
      trip_d_r <= 1'b0;
    end else begin
      drv_s1_r <= DRV_STAT;
      drv_s2_r <= drv_s1_r;
      trip_d_r <= drv_s2_r.trip;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge detection against the previous image, and of the trip against trip_d_r
  // only a fresh image can make a request edge, so a held bit never retriggers
  always_comb begin
    rise_cmd   = RY_STROBE & RY_IMAGE[RBH_RY_CMD] &
                 ~ry_cur_r[RBH_RY_CMD];
    fall_alrst = RY_STROBE & ~RY_IMAGE[RBH_RY_ALRST] &
                 ry_cur_r[RBH_RY_ALRST];
    trip_rise  = drv_s2_r.trip & ~trip_d_r;
  end

  // image register, updated on every cyclic strobe
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ry_cur_r <= RBH_IMG_RST;
    end else if (RY_STROBE) begin
      ry_cur_r <= RY_IMAGE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // level requests towards the drive
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mon_refresh_r <= 1'b0;
      ref_apply_r   <= 1'b0;
      term_cmd_r    <= 9'h000;
    end else begin
      // held request keeps refreshing, not a single snapshot
      mon_refresh_r <= ry_cur_r[RBH_RY_MON];
      ref_apply_r   <= ry_cur_r[RBH_RY_REF];
      // terminals not operable over the link read as off
      term_cmd_r    <= rbh_term_bits(ry_cur_r) & mask_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // monitor and reference completion flags
  // the request level is the only clear; a done with the request
  // already gone has nothing to report, so the clear wins there
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      monitoring_r <= 1'b0;
      ref_done_r   <= 1'b0;
    end else begin
      if (!ry_cur_r[RBH_RY_MON]) begin
        monitoring_r <= 1'b0;
      end else if (drv_s2_r.mon_done) begin
        monitoring_r <= 1'b1;
      end
      if (!ry_cur_r[RBH_RY_REF]) begin
        ref_done_r <= 1'b0;
      end else if (drv_s2_r.ref_done) begin
        ref_done_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command handshake, next state
  always_comb begin
    cmd_state_nxt = cmd_state_r;
    case (cmd_state_r)
      RBH_CMD_IDLE: begin
        if (rise_cmd) begin
          cmd_state_nxt = RBH_CMD_BUSY;
        end
      end
      RBH_CMD_BUSY: begin
        // finish the started command even if the request is dropped
        if (drv_s2_r.cmd_done) begin
          cmd_state_nxt = ry_cur_r[RBH_RY_CMD] ? RBH_CMD_DONE
                                               : RBH_CMD_IDLE;
        end
      end
      RBH_CMD_DONE: begin
        if (!ry_cur_r[RBH_RY_CMD]) begin
          cmd_state_nxt = RBH_CMD_IDLE;
        end
      end
      default: begin
        cmd_state_nxt = RBH_CMD_IDLE;
      end
    endcase
  end

  // command state and start pulse
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmd_state_r <= RBH_CMD_IDLE;
      cmd_start_r <= 1'b0;
      cmd_cnt_r   <= RBH_CNT_RST;
    end else begin
      cmd_state_r <= cmd_state_nxt;
      // one pulse per rising request seen in idle; a held bit never repeats
      cmd_start_r <= (cmd_state_r == RBH_CMD_IDLE) & rise_cmd;
      if ((cmd_state_r == RBH_CMD_IDLE) && rise_cmd) begin
        cmd_cnt_r <= cmd_cnt_r + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm and station ready
  // a trip in the same cycle as a reset edge wins
  always_comb begin
    if (trip_rise) begin
      alarm_nxt = 1'b1;
    end else if (fall_alrst) begin
      alarm_nxt = 1'b0;
    end else begin
      alarm_nxt = alarm_r;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      alarm_r       <= 1'b0;
      ready_r       <= 1'b0;
      alarm_reset_r <= 1'b0;
    end else begin
      alarm_r       <= alarm_nxt;
      // ready follows the drive but drops in the alarm's own update
      ready_r       <= drv_s2_r.ready & ~alarm_nxt;
      // only a falling request edge resets the drive trip
      alarm_reset_r <= fall_alrst & alarm_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // running direction and terminal states
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fwd_r     <= 1'b0;
      rev_r     <= 1'b0;
      term_st_r <= 6'h00;
    end else begin
      // both asserted is not a real rotation, show neither
      fwd_r     <= drv_s2_r.fwd & ~drv_s2_r.rev;
      rev_r     <= drv_s2_r.rev & ~drv_s2_r.fwd;
      term_st_r <= drv_s2_r.term;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: no wait state, answer in the first access cycle
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= APB_REQ.psel & ~APB_REQ.penable;
      pslverr_r <= APB_REQ.psel & ~APB_REQ.penable &
                   ~rbh_mapped(APB_REQ.paddr);
      prdata_r  <= 32'h0000_0000;
      if (APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite) begin
        case (APB_REQ.paddr)
          RBH_OFS_CTRL:    prdata_r <= {23'h000000, mask_r};
          RBH_OFS_STATUS:  prdata_r <= RX_IMAGE;
          RBH_OFS_REQUEST: prdata_r <= ry_cur_r;
          RBH_OFS_CMDCNT:  prdata_r <= {16'h0000, cmd_cnt_r};
          default:         prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control write, taken at the completing access edge
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mask_r <= RBH_MASK_RST;
    end else if (APB_REQ.psel && APB_REQ.penable && pready_r &&
                 APB_REQ.pwrite && APB_REQ.paddr == RBH_OFS_CTRL) begin
      mask_r <= APB_REQ.pwdata[8:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops, except the command done bit decoded from cmd_state_r
  always_comb begin
    RX_IMAGE                  = 32'h0000_0000;
    RX_IMAGE[RBH_RX_FWD]      = fwd_r;
    RX_IMAGE[RBH_RX_REV]      = rev_r;
    RX_IMAGE[RBH_RX_TERM_LO +: 6] = term_st_r;
    RX_IMAGE[RBH_RX_MON]      = monitoring_r;
    RX_IMAGE[RBH_RX_REF]      = ref_done_r;
    RX_IMAGE[RBH_RX_CMD]      = cmd_state_r == RBH_CMD_DONE;
    RX_IMAGE[RBH_RX_ALARM]    = alarm_r;
    RX_IMAGE[RBH_RX_READY]    = ready_r;
  end

  assign PRDATA          = prdata_r;
  assign PREADY          = pready_r;
  assign PSLVERR         = pslverr_r;
  assign DRV_MON_REFRESH = mon_refresh_r;
  assign DRV_REF_APPLY   = ref_apply_r;
  assign DRV_CMD_START   = cmd_start_r;
  assign DRV_ALARM_RESET = alarm_reset_r;
  assign DRV_TERM_CMD    = term_cmd_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  property p_mon_follow;
    ##1 (mon_refresh_r == $past(ry_cur_r[RBH_RY_MON]));
  endproperty
  a_mon_follow: assert property (p_mon_follow)
    else $error("monitor refresh not held");

  property p_ref_follow;
    ##1 (ref_apply_r == $past(ry_cur_r[RBH_RY_REF]));
  endproperty
  a_ref_follow: assert property (p_ref_follow)
    else $error("reference apply not held");

  property p_cmd_once;
    cmd_start_r |-> $past(rise_cmd) ##1 !cmd_start_r;
  endproperty
  a_cmd_once: assert property (p_cmd_once)
    else $error("command start without fresh request edge");

  property p_alrst_edge;
    alarm_reset_r |-> $past(fall_alrst) && !alarm_r;
  endproperty
  a_alrst_edge: assert property (p_alrst_edge)
    else $error("alarm reset without falling request");

  property p_fwd;
    ##2 (fwd_r == ($past(drv_s2_r.fwd) & ~$past(drv_s2_r.rev)));
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("forward status wrong");

  property p_mon_clear;
    !ry_cur_r[RBH_RY_MON] |=> !monitoring_r;
  endproperty
  a_mon_clear: assert property (p_mon_clear)
    else $error("monitoring status stuck");

  property p_cmd_done_drop;
    (cmd_state_r == RBH_CMD_DONE) && !ry_cur_r[RBH_RY_CMD]
      |=> !RX_IMAGE[RBH_RX_CMD];
  endproperty
  a_cmd_done_drop: assert property (p_cmd_done_drop)
    else $error("command done not cleared");

  property p_trip_ready;
    $rose(alarm_r) |-> !ready_r;
  endproperty
  a_trip_ready: assert property (p_trip_ready)
    else $error("ready still high with new alarm");

  property p_term_gate;
    ##1 ((term_cmd_r & ~$past(mask_r)) == 9'h000);
  endproperty
  a_term_gate: assert property (p_term_gate)
    else $error("masked terminal command passed");

  c_cmd_done:  cover property ($rose(RX_IMAGE[RBH_RX_CMD]));
  c_alarm_clr: cover property ($fell(alarm_r));
  c_mon_on:    cover property ($rose(monitoring_r));

endmodule

// file: rbh_master_model.sv
`timescale 1ns/1ps
// fieldbus master stand-in: every fourth cycle sends the wanted image while ready, else only its alarm reset bit
module rbh_master_model
  import rbh_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // wanted request bits and returned status
  input  wire logic [31:0] want,
  input  wire logic [31:0] rx_image,
  // cyclic image toward the device
  output logic [31:0]      ry_image,
  output logic             ry_strobe
);
  ////////////////////////////////////////////////////////////////////////
  logic [1:0] tick_r; // spacing between images

  // image cycle, strobe for one clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_r    <= 2'h0;
      ry_strobe <= 1'b0;
      ry_image  <= 32'h0000_0000;
    end else begin
      tick_r    <= tick_r + 2'h1;
      ry_strobe <= (tick_r == 2'h3);
      if (tick_r == 2'h3) begin
        // requests only while ready; alarm reset kept so a trip can clear
        ry_image <= rx_image[RBH_RX_READY] ? want
                  : (want & (32'h1 << RBH_RY_ALRST));
      end
    end
  end
endmodule

// file: remote_bit_handshake_tb.sv
`timescale 1ns/1ps
// self-checking bench for the remote bit handshake core
module remote_bit_handshake_tb
  import rbh_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////
  logic          SYS_CLK;  // 20 MHz
  logic          RESETN;   // async, active low
  rbh_apb_req_s  req;      // apb master signals
  logic [31:0]   PRDATA;
  logic          PREADY;
  logic          PSLVERR;
  logic [31:0]   ry_image; // from master model
  logic          ry_strobe;
  logic [31:0]   RX_IMAGE;
  rbh_drv_stat_s stat;     // drive pins
  logic          mon_refresh;
  logic          ref_apply;
  logic          cmd_start;
  logic          alarm_reset;
  logic [8:0]    term_cmd;
  logic [31:0]   want;     // request bits the master sends
  logic [31:0]   q;        // read data
  logic          e;        // slave error
  int            fails;
  int            compares;
  int            n_start = 0; // command start pulses
  int            n_alrst = 0; // alarm reset pulses
  int            cyc     = 0; // timeout counter

  rbh_core rbh_core_i (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .APB_REQ(req), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RY_IMAGE(ry_image),
    .RY_STROBE(ry_strobe), .RX_IMAGE(RX_IMAGE), .DRV_STAT(stat),
    .DRV_MON_REFRESH(mon_refresh), .DRV_REF_APPLY(ref_apply),
    .DRV_CMD_START(cmd_start), .DRV_ALARM_RESET(alarm_reset),
    .DRV_TERM_CMD(term_cmd));

  rbh_master_model rbh_master_model_i (
    .clk(SYS_CLK), .rst_n(RESETN), .want(want), .rx_image(RX_IMAGE),
    .ry_image(ry_image), .ry_strobe(ry_strobe));

  ////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    SYS_CLK = 1'b0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end

  // pulse counters and the run limit
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cmd_start === 1'b1) n_start <= n_start + 1;
    if (alarm_reset === 1'b1) n_alrst <= n_alrst + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares = compares + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge SYS_CLK);
    req <= {1'b1, 1'b0, wr, a, d};
    @(posedge SYS_CLK);
    req.penable <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    req <= '0;
  endtask

  // images go out every fourth cycle; give three of them time to land
  task automatic settle();
    repeat (12) @(posedge SYS_CLK);
  endtask

  task automatic wrap_up();
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    RESETN = 1'b0;
    req = '0;
    stat = '0;
    want = 32'h0;
    fails = 0;
    compares = 0;
    repeat (20) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    chk("rx after reset", RX_IMAGE, 32'h0);
    apb(1'b0, RBH_OFS_CTRL, 32'h0);
    chk("ctrl reset", q, {23'h0, RBH_MASK_RST});
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", q, 32'h0);
    // drive ready, then direction and terminal pins
    stat.ready <= 1'b1;
    settle();
    chk("ready", RX_IMAGE[27:26], 2'b10);
    stat.fwd <= 1'b1;
    stat.term <= 6'h2d;
    settle();
    chk("fwd", RX_IMAGE[7:0], {6'h2d, 2'b01});
    stat.fwd <= 1'b0;
    stat.rev <= 1'b1;
    settle();
    chk("rev", RX_IMAGE[1:0], 2'b10);
    // both direction pins high is no real rotation
    stat.fwd <= 1'b1;
    settle();
    chk("both dirs", RX_IMAGE[1:0], 2'b00);
    stat.fwd <= 1'b0;
    // monitor and reference handshakes, done held high past the drop
    for (int i = 0; i < 2; i++) begin
      want[12+i] <= 1'b1;
      settle();
      chk("apply on", i ? ref_apply : mon_refresh, 1'b1);
      chk("flag early", RX_IMAGE[12+i], 1'b0);
      if (i == 0) stat.mon_done <= 1'b1;
      else stat.ref_done <= 1'b1;
      settle();
      chk("flag set", RX_IMAGE[12+i], 1'b1);
      want[12+i] <= 1'b0;
      settle();
      chk("flag drop", RX_IMAGE[12+i], 1'b0);
      chk("apply off", i ? ref_apply : mon_refresh, 1'b0);
    end
    // command: one start per rising request, held across many images
    want[15] <= 1'b1;
    settle();
    chk("one start", n_start, 1);
    stat.cmd_done <= 1'b1;
    settle();
    chk("cmd done", RX_IMAGE[15], 1'b1);
    chk("no repeat", n_start, 1);
    want[15] <= 1'b0;
    settle();
    chk("cmd done drop", RX_IMAGE[15], 1'b0);
    stat.cmd_done <= 1'b0;
    want[15] <= 1'b1;
    settle();
    chk("restart", n_start, 2);
    want[15] <= 1'b0;
    apb(1'b0, RBH_OFS_CMDCNT, 32'h0);
    chk("cmd count", q, 32'h2);
    // a command finishing after its request dropped shows no done
    stat.cmd_done <= 1'b1;
    settle();
    chk("late done hidden", RX_IMAGE[15], 1'b0);
    // terminal commands only where the link may drive them
    apb(1'b1, RBH_OFS_CTRL, 32'h0f0);
    apb(1'b1, RBH_OFS_STATUS, 32'hffff_ffff);
    chk("ro write err", {31'h0, e}, 32'h0);
    want[11:2] <= 10'h37f;
    settle();
    chk("term mask", term_cmd, 9'h0f0);
    apb(1'b0, RBH_OFS_REQUEST, 32'h0);
    chk("request image", q, 32'h0dfc);
    want[11:2] <= 10'h0;
    // trip, then alarm reset acting on the falling request only
    stat.trip <= 1'b1;
    settle();
    chk("trip", RX_IMAGE[27:26], 2'b01);
    want[26] <= 1'b1;
    settle();
    chk("no reset on rise", n_alrst, 0);
    want[26] <= 1'b0;
    settle();
    chk("reset on fall", n_alrst, 1);
    chk("alarm cleared", RX_IMAGE[26], 1'b0);
    stat.trip <= 1'b0;
    // a falling request with no alarm standing gives no reset pulse
    want[26] <= 1'b1;
    settle();
    want[26] <= 1'b0;
    settle();
    chk("no alarm no reset", n_alrst, 1);
    // status word over the bus: ready, reverse and terminal pins
    apb(1'b0, RBH_OFS_STATUS, 32'h0);
    chk("status read", q, 32'h0800_00b6);
    // reset again in mid-run: status and mask back to reset values
    RESETN <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    chk("rx after rerun", RX_IMAGE, 32'h0);
    apb(1'b0, RBH_OFS_CTRL, 32'h0);
    chk("ctrl after rerun", q, {23'h0, RBH_MASK_RST});
    settle();
    chk("ready again", RX_IMAGE[27:26], 2'b10);
    wrap_up();
  end
endmodule
